//--- hdl/cal_arith_unit.sv
// cal_arith_unit: 8-bit arithmetic/logic datapath of the core, run from an AXI4-Lite register file.
// assumes: software loads operands, then writes the control word with go set; one clock, sync reset.
// Operation
// - dec: operand minus one, carry clear on 00
// - decc: subtract one minus carry, carry rule
// - and/or: result to both, zero only
// - xor: result to both, c/v kept
// - add: eight-bit sum, carry out
// - addc: carry as extra addend
// - subd: second minus register, carry no-borrow
// - subdc: also minus one minus carry
// - subs: register minus second, reg3-reg2
// - subsc: straight difference minus borrow
// - mul: low byte acc, high dest
// - mshl: register times two to shift
// - cmp: acc only, v = c and not z
// - tstb: keep selected bit, others zero
// - setb: force bit one, copy to acc
// - clrb: force bit zero, copy to acc
// - invb: flip bit, copy to acc
// - memory operand address and index update
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module cal_arith_unit (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// write address channel
	input  wire logic [cal_pkg::CAL_AW-1:0]  awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	// write data channel
	input  wire logic [cal_pkg::CAL_DW-1:0]  wdata,
	input  wire logic [cal_pkg::CAL_LANES-1:0] wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	// write response channel
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	// read address channel
	input  wire logic [cal_pkg::CAL_AW-1:0]  araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	// read data channel
	output logic [cal_pkg::CAL_DW-1:0]       rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready
);
	import cal_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state of the whole unit
	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arready;
		logic                 rvalid;
		logic [CAL_DW-1:0]    rdata;
		logic [1:0]           rresp;
		logic                 aw_held;
		logic [CAL_AW-1:0]    aw_addr;
		logic                 w_held;
		logic [CAL_DW-1:0]    w_data;
		logic [CAL_LANES-1:0] w_strb;
		logic [CAL_DW-1:0]    ctrl;
		logic [7:0]           opa;
		logic [7:0]           opb;
		logic [7:0]           opc;
		logic                 c;
		logic                 v;
		logic                 z;
		logic [7:0]           acc;
		logic [7:0]           dest;
		logic                 dest_wr;
		logic [15:0]          index;
		logic [15:0]          maddr;
		logic                 bad_op;
	} cal_state_s;

	cal_state_s  s_q;
	cal_state_s  s_d;

	logic              do_write;
	logic [CAL_DW-1:0] ctrl_eff;
	cal_op_e           op;
	cal_form_e         form;
	cal_mode_e         mode;
	logic [2:0]        sel;
	logic [7:0]        offs;
	logic [7:0]        u_opd;
	logic [7:0]        v_opd;
	logic [7:0]        x_opd;
	logic [7:0]        bit_mask;
	logic [7:0]        ad_a;
	logic [7:0]        ad_b;
	logic              ad_cin;
	logic [7:0]        ad_sum;
	logic              ad_cout;
	logic              ad_ovf;
	logic [15:0]       prod;
	logic [15:0]       shifted;
	logic [3:0]        rsh_amt;
	logic [7:0]        res_acc;
	logic [7:0]        res_dest;
	logic              res_c;
	logic              res_v;
	logic              res_dwr;
	logic              res_zupd;
	logic              op_ok;
	logic [15:0]       offs16;
	logic [15:0]       ea_addr;
	logic [15:0]       ea_index;

	// byte-lane merge of a write into an old word
	function automatic logic [CAL_DW-1:0] cal_wmerge(input logic [CAL_DW-1:0] old_v,
	                                                 input logic [CAL_DW-1:0] new_v,
	                                                 input logic [CAL_LANES-1:0] strb);
		logic [CAL_DW-1:0] m;
		m = old_v;
		for (int i = 0; i < CAL_LANES; i++) begin
			if (strb[i]) begin
				m[i*CAL_BYTE +: CAL_BYTE] = new_v[i*CAL_BYTE +: CAL_BYTE];
			end
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// decode of the control word as it will stand after a pending write
	assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
	assign ctrl_eff = cal_wmerge(s_q.ctrl, s_q.w_data, s_q.w_strb);
	assign op       = cal_op_e'(ctrl_eff[CAL_OP_LSB +: CAL_OP_W]);
	assign form     = cal_form_e'(ctrl_eff[CAL_FORM_LSB +: 2]);
	assign mode     = cal_mode_e'(ctrl_eff[CAL_MODE_LSB +: 3]);
	assign sel      = ctrl_eff[CAL_SEL_LSB +: 3];
	assign offs     = ctrl_eff[CAL_OFFS_LSB +: CAL_BYTE];

	// three-register form feeds reg2/reg3, the others reg (or reg1) and the second operand
	assign u_opd    = (form == CAL_FORM_R3) ? s_q.opb : s_q.opa;
	assign v_opd    = (form == CAL_FORM_R3) ? s_q.opc : s_q.opb;
	// dec and decc: "reg1,reg2" and memory forms read the second operand
	assign x_opd    = (form == CAL_FORM_R2 || form == CAL_FORM_MEM) ? s_q.opb : s_q.opa;
	assign bit_mask = CAL_BIT_ONE << sel;

	////////////////////////////////////////////////////////////////////////////////
	// adder operand steering; every carry-using op shares the one adder
	always_comb begin
		ad_a   = CAL_BYTE_ZERO;
		ad_b   = CAL_BYTE_ZERO;
		ad_cin = 1'b0;
		unique case (op)
			CAL_OP_DEC: begin
				ad_a = x_opd;
				ad_b = CAL_ALL_ONES;
			end
			CAL_OP_DECC: begin
				ad_a   = x_opd;
				ad_b   = CAL_ALL_ONES;
				ad_cin = s_q.c;
			end
			CAL_OP_ADD: begin
				ad_a = u_opd;
				ad_b = v_opd;
			end
			CAL_OP_ADDC: begin
				ad_a   = u_opd;
				ad_b   = v_opd;
				ad_cin = s_q.c;
			end
			CAL_OP_SUBD, CAL_OP_SUBDC: begin
				ad_a   = (form == CAL_FORM_R3) ? u_opd : v_opd;
				ad_b   = (form == CAL_FORM_R3) ? ~v_opd : ~u_opd;
				ad_cin = (op == CAL_OP_SUBD) ? 1'b1 : s_q.c;
			end
			// straight subtract, reg3-reg2 in three-register form
			CAL_OP_SUBS, CAL_OP_SUBSC: begin
				ad_a   = (form == CAL_FORM_R3) ? v_opd : u_opd;
				ad_b   = (form == CAL_FORM_R3) ? ~u_opd : ~v_opd;
				ad_cin = (op == CAL_OP_SUBS) ? 1'b1 : s_q.c;
			end
			CAL_OP_CMP, CAL_OP_CMPA: begin
				ad_a   = s_q.opb;
				ad_b   = ~s_q.opa;
				ad_cin = 1'b1;
			end
			default: begin
				ad_cin = 1'b0;
			end
		endcase
	end

	cal_addsub #(
		.W    (CAL_BYTE)
	) u_addsub (
		.a    (ad_a),
		.b    (ad_b),
		.cin  (ad_cin),
		.sum  (ad_sum),
		.cout (ad_cout),
		.ovf  (ad_ovf)
	);

	assign prod    = {CAL_BYTE_ZERO, u_opd} * {CAL_BYTE_ZERO, v_opd};
	// right variants shift left by eight minus the amount
	assign rsh_amt = CAL_MSH_SPAN - {1'b0, sel};

	// shifter for the multiply-shift ops
	always_comb begin
		unique case (op)
			CAL_OP_MSHL:  shifted = {CAL_BYTE_ZERO, s_q.opa} << {1'b0, sel};
			// arithmetic variant keeps the sign in the high byte
			CAL_OP_MSHRA: shifted = {{CAL_BYTE{s_q.opa[7]}}, s_q.opa} << rsh_amt;
			default:      shifted = {CAL_BYTE_ZERO, s_q.opa} << rsh_amt;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// result and flag selection per operation
	always_comb begin
		res_acc  = ad_sum;
		res_dest = ad_sum;
		res_c    = ad_cout;
		res_v    = ad_ovf;
		res_dwr  = 1'b1;
		res_zupd = 1'b1;
		op_ok    = 1'b1;
		unique case (op)
			// carry is the adder's carry out; no borrow reads as carry set
			CAL_OP_DEC, CAL_OP_DECC, CAL_OP_ADD, CAL_OP_ADDC,
			CAL_OP_SUBD, CAL_OP_SUBDC, CAL_OP_SUBS, CAL_OP_SUBSC: begin
				res_acc = ad_sum;
			end
			// and, flags other than zero kept
			CAL_OP_AND: begin
				res_acc  = u_opd & v_opd;
				res_dest = u_opd & v_opd;
				res_c    = s_q.c;
				res_v    = s_q.v;
			end
			CAL_OP_OR: begin
				res_acc  = u_opd | v_opd;
				res_dest = u_opd | v_opd;
				res_c    = s_q.c;
				res_v    = s_q.v;
			end
			// xor in every form, memory included
			CAL_OP_XOR: begin
				res_acc  = u_opd ^ v_opd;
				res_dest = u_opd ^ v_opd;
				res_c    = s_q.c;
				res_v    = s_q.v;
			end
			// split product; flags are undefined, so they are simply kept
			CAL_OP_MUL, CAL_OP_MULA: begin
				res_acc  = prod[7:0];
				res_dest = prod[15:8];
				res_c    = s_q.c;
				res_v    = s_q.v;
				res_zupd = 1'b0;
			end
			CAL_OP_MSHL, CAL_OP_MSHR, CAL_OP_MSHRA: begin
				res_acc  = shifted[7:0];
				res_dest = shifted[15:8];
				res_c    = s_q.c;
				res_v    = s_q.v;
				res_zupd = 1'b0;
			end
			CAL_OP_CMP, CAL_OP_CMPA: begin
				res_dest = s_q.opa;
				res_dwr  = 1'b0;
				res_v    = ad_cout && (ad_sum != CAL_BYTE_ZERO);
			end
			CAL_OP_TSTB: begin
				res_acc  = s_q.opa & bit_mask;
				res_dest = s_q.opa;
				res_dwr  = 1'b0;
				res_c    = s_q.c;
				res_v    = s_q.v;
			end
			CAL_OP_SETB: begin
				res_acc  = s_q.opa | bit_mask;
				res_dest = s_q.opa | bit_mask;
				res_c    = s_q.c;
				res_v    = s_q.v;
			end
			CAL_OP_CLRB: begin
				res_acc  = s_q.opa & ~bit_mask;
				res_dest = s_q.opa & ~bit_mask;
				res_c    = s_q.c;
				res_v    = s_q.v;
			end
			CAL_OP_INVB: begin
				res_acc  = s_q.opa ^ bit_mask;
				res_dest = s_q.opa ^ bit_mask;
				res_c    = s_q.c;
				res_v    = s_q.v;
			end
			// unused opcode: no result, flag or index change, status reports it
			default: begin
				op_ok = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// extended address and index update for the memory form
	assign offs16 = {CAL_BYTE_ZERO, offs};

	always_comb begin
		ea_addr  = s_q.index;
		ea_index = s_q.index;
		unique case (mode)
			CAL_EA_DIRECT:  ea_addr = offs16;
			CAL_EA_IX:      ea_addr = s_q.index;
			CAL_EA_IX_OFS:  ea_addr = s_q.index + offs16;
			CAL_EA_IX_R3:   ea_addr = s_q.index + {CAL_BYTE_ZERO, s_q.opc};
			// index moves in the same operation
			CAL_EA_POST:    ea_index = s_q.index + CAL_IDX_STEP;
			CAL_EA_OFSPOST: begin
				ea_addr  = s_q.index + offs16;
				ea_index = s_q.index + offs16;
			end
			CAL_EA_PREDEC:  begin
				ea_addr  = s_q.index - CAL_IDX_STEP;
				ea_index = s_q.index - CAL_IDX_STEP;
			end
			CAL_EA_OFSPRE:  begin
				ea_addr  = s_q.index - offs16;
				ea_index = s_q.index - offs16;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state: bus channels, register writes, execution
	always_comb begin
		s_d = s_q;
		// address and data may arrive in either order; each is held until both are in
		if (s_q.awready && awvalid) begin
			s_d.aw_held = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (s_q.wready && wvalid) begin
			s_d.w_held = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (do_write) begin
			s_d.aw_held = 1'b0;
			s_d.w_held  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = CAL_RESP_OKAY;
			unique case (s_q.aw_addr)
				CAL_OFS_CTRL: begin
					s_d.ctrl             = ctrl_eff;
					s_d.ctrl[CAL_GO_BIT] = 1'b0;
					if (ctrl_eff[CAL_GO_BIT] && op_ok) begin
						if (res_zupd) begin
							s_d.z = (res_acc == CAL_BYTE_ZERO);
						end
						s_d.acc     = res_acc;
						s_d.dest    = res_dest;
						s_d.dest_wr = res_dwr;
						s_d.c       = res_c;
						s_d.v       = res_v;
						// location and index update land together
						if (form == CAL_FORM_MEM) begin
							s_d.maddr = ea_addr;
							s_d.index = ea_index;
						end
					end
					if (ctrl_eff[CAL_GO_BIT] && !op_ok) begin
						s_d.bad_op = 1'b1;
					end
				end
				CAL_OFS_OPA:    if (s_q.w_strb[0]) s_d.opa = s_q.w_data[7:0];
				CAL_OFS_OPB:    if (s_q.w_strb[0]) s_d.opb = s_q.w_data[7:0];
				CAL_OFS_OPC:    if (s_q.w_strb[0]) s_d.opc = s_q.w_data[7:0];
				CAL_OFS_FLAGS:  if (s_q.w_strb[0]) begin
					s_d.c = s_q.w_data[CAL_FLAG_C];
					s_d.v = s_q.w_data[CAL_FLAG_V];
					s_d.z = s_q.w_data[CAL_FLAG_Z];
				end
				CAL_OFS_INDEX:  s_d.index = 16'(cal_wmerge({16'h0000, s_q.index}, s_q.w_data, s_q.w_strb));
				// write one to clear the bad-opcode mark
				CAL_OFS_STATUS: if (s_q.w_strb[0] && s_q.w_data[CAL_ST_BADOP]) s_d.bad_op = 1'b0;
				CAL_OFS_RESULT, CAL_OFS_MADDR: s_d.bresp = CAL_RESP_OKAY;
				default:        s_d.bresp = CAL_RESP_SLVERR;
			endcase
		end
		// read side: one outstanding read, data held until taken
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_q.arready && arvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = CAL_RESP_OKAY;
			s_d.rdata  = '0;
			unique case (araddr)
				CAL_OFS_CTRL:   s_d.rdata = s_q.ctrl;
				CAL_OFS_OPA:    s_d.rdata[7:0] = s_q.opa;
				CAL_OFS_OPB:    s_d.rdata[7:0] = s_q.opb;
				CAL_OFS_OPC:    s_d.rdata[7:0] = s_q.opc;
				CAL_OFS_FLAGS:  s_d.rdata[2:0] = {s_q.z, s_q.v, s_q.c};
				CAL_OFS_RESULT: s_d.rdata[15:0] = {s_q.dest, s_q.acc};
				CAL_OFS_INDEX:  s_d.rdata[15:0] = s_q.index;
				CAL_OFS_MADDR:  s_d.rdata[15:0] = s_q.maddr;
				CAL_OFS_STATUS: s_d.rdata[1:0] = {s_q.dest_wr, s_q.bad_op};
				default:        s_d.rresp = CAL_RESP_SLVERR;
			endcase
		end
		// readies are registered from the next state, so they drop in the cycle right after a take
		s_d.awready = !s_d.aw_held && !s_d.bvalid;
		s_d.wready  = !s_d.w_held && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	// single register stage for all state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ports straight from the state register
	assign awready = s_q.awready;
	assign wready  = s_q.wready;
	assign bvalid  = s_q.bvalid;
	assign bresp   = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid  = s_q.rvalid;
	assign rdata   = s_q.rdata;
	assign rresp   = s_q.rresp;

endmodule

//--- hdl/cal_pkg.sv
// cal_pkg: constants, opcodes, operand forms and address modes of the arithmetic/logic unit.
// assumes: shared by the unit, its bus checker and the bench; the register map sits behind an AXI4-Lite slave.
package cal_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus shape
	localparam int          CAL_AW          = 8;
	localparam int          CAL_DW          = 32;
	localparam int          CAL_BYTE        = 8;
	localparam int          CAL_LANES       = 4;
	localparam logic [1:0]  CAL_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  CAL_RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0]  CAL_OFS_CTRL    = 8'h00;
	localparam logic [7:0]  CAL_OFS_OPA     = 8'h04;
	localparam logic [7:0]  CAL_OFS_OPB     = 8'h08;
	localparam logic [7:0]  CAL_OFS_OPC     = 8'h0c;
	localparam logic [7:0]  CAL_OFS_FLAGS   = 8'h10;
	localparam logic [7:0]  CAL_OFS_RESULT  = 8'h14;
	localparam logic [7:0]  CAL_OFS_INDEX   = 8'h18;
	localparam logic [7:0]  CAL_OFS_MADDR   = 8'h1c;
	localparam logic [7:0]  CAL_OFS_STATUS  = 8'h20;

	////////////////////////////////////////////////////////////////////////////////
	// control word, flag and status bit fields
	localparam int          CAL_OP_LSB      = 0;
	localparam int          CAL_OP_W        = 5;
	localparam int          CAL_FORM_LSB    = 6;
	localparam int          CAL_SEL_LSB     = 8;
	localparam int          CAL_MODE_LSB    = 12;
	localparam int          CAL_GO_BIT      = 16;
	localparam int          CAL_OFFS_LSB    = 24;
	localparam int          CAL_FLAG_C      = 0;
	localparam int          CAL_FLAG_V      = 1;
	localparam int          CAL_FLAG_Z      = 2;
	localparam int          CAL_ST_BADOP    = 0;
	localparam int          CAL_ST_DESTWR   = 1;

	////////////////////////////////////////////////////////////////////////////////
	// datapath constants
	localparam logic [7:0]  CAL_ALL_ONES    = 8'hff;
	localparam logic [7:0]  CAL_BYTE_ZERO   = 8'h00;
	localparam logic [7:0]  CAL_BIT_ONE     = 8'h01;
	localparam logic [3:0]  CAL_MSH_SPAN    = 4'h8;
	localparam logic [15:0] CAL_IDX_STEP    = 16'h0001;
	localparam logic [31:0] CAL_CTRL_RST    = 32'h0000_0000;

	typedef enum logic [4:0] {
		CAL_OP_DEC   = 5'h00, CAL_OP_DECC  = 5'h01, CAL_OP_AND   = 5'h02, CAL_OP_OR    = 5'h03,
		CAL_OP_XOR   = 5'h04, CAL_OP_ADD   = 5'h05, CAL_OP_ADDC  = 5'h06, CAL_OP_SUBD  = 5'h07,
		CAL_OP_SUBDC = 5'h08, CAL_OP_SUBS  = 5'h09, CAL_OP_SUBSC = 5'h0a, CAL_OP_MUL   = 5'h0b,
		CAL_OP_MULA  = 5'h0c, CAL_OP_MSHL  = 5'h0d, CAL_OP_MSHR  = 5'h0e, CAL_OP_MSHRA = 5'h0f,
		CAL_OP_CMP   = 5'h10, CAL_OP_CMPA  = 5'h11, CAL_OP_TSTB  = 5'h12, CAL_OP_SETB  = 5'h13,
		CAL_OP_CLRB  = 5'h14, CAL_OP_INVB  = 5'h15
	} cal_op_e;

	typedef enum logic [1:0] {
		CAL_FORM_IMM = 2'h0, CAL_FORM_R3 = 2'h1, CAL_FORM_R2 = 2'h2, CAL_FORM_MEM = 2'h3
	} cal_form_e;

	typedef enum logic [2:0] {
		CAL_EA_DIRECT  = 3'h0, CAL_EA_IX      = 3'h1, CAL_EA_IX_OFS  = 3'h2, CAL_EA_IX_R3   = 3'h3,
		CAL_EA_POST    = 3'h4, CAL_EA_OFSPOST = 3'h5, CAL_EA_PREDEC  = 3'h6, CAL_EA_OFSPRE  = 3'h7
	} cal_mode_e;

endpackage

//--- hdl/cal_addsub.sv
// cal_addsub: plain adder with carry in, carry out and signed overflow.
// assumes: subtraction is done by the caller feeding the inverted subtrahend.
`timescale 1ns/10ps
module cal_addsub #(
	parameter int W = 8
) (
	// operands
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire logic         cin,
	// result
	output logic      [W-1:0] sum,
	output logic              cout,
	output logic              ovf
);

	// widened by one bit so the carry is never lost
	assign {cout, sum} = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
	// signed overflow when both inputs agree in sign and the sum does not
	assign ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);

endmodule

//--- tb/cal_arith_unit_asserts.sv
// cal_arith_unit_asserts: bus timing checks on the unit's register port.
// assumes: bound to cal_arith_unit; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module cal_arith_unit_chk (
	// clock and reset
	input wire logic                      aclk,
	input wire logic                      aresetn,
	// write side
	input wire logic                      awvalid,
	input wire logic                      awready,
	input wire logic                      wvalid,
	input wire logic                      wready,
	input wire logic [1:0]                bresp,
	input wire logic                      bvalid,
	input wire logic                      bready,
	// read side
	input wire logic                      arvalid,
	input wire logic                      arready,
	input wire logic [cal_pkg::CAL_DW-1:0] rdata,
	input wire logic [1:0]                rresp,
	input wire logic                      rvalid,
	input wire logic                      rready
);
	import cal_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// write steps: both taken together, then response after one idle cycle
	sequence s_wr_both;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_resp_late;
		!bvalid ##1 bvalid;
	endsequence
	AST_B_RESP: assert property (s_wr_both |=> s_resp_late) // write response
		else $error("write response not two cycles after address and data");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) // response held
		else $error("write response dropped before bready");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)) // read held
		else $error("read data changed before rready");
	AST_R_NEXT: assert property (arvalid && arready |=> rvalid) // read answer
		else $error("read data not one cycle after address");
	AST_AR_LOW: assert property (rvalid |-> !arready) // one read at a time
		else $error("read address ready while data pending");
	AST_AW_LOW: assert property (awvalid && awready |=> !awready [*2]) // one write at a time
		else $error("write address ready while write under way");
	AST_W_BACK: assert property (bvalid && bready |=> wready && awready) // ready returns
		else $error("write data ready not back one cycle after response");
	AST_RST_IDLE: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !awready) // reset idle
		else $error("outputs not idle at reset release");
	AST_RESP_CODE: assert property (bvalid |-> bresp == CAL_RESP_OKAY || bresp == CAL_RESP_SLVERR) // codes
		else $error("write response code not okay or slave error");
endmodule
bind cal_arith_unit cal_arith_unit_chk u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

//--- tb/cal_dmem_model.sv
// cal_dmem_model: data memory beside the core, one byte per 16-bit address.
// assumes: read only; contents are a fixed pattern of the address so any byte is known.
`timescale 1ns/10ps
module cal_dmem_model (
	// lookup
	input wire logic [15:0] addr,
	// byte stored there
	output logic     [7:0]  data
);
	assign data = addr[15:8] ^ addr[7:0] ^ 8'h5a;
endmodule

//--- tb/tb.sv
// tb: self-checking bench driving the unit through its register bus.
// assumes: cal_pkg, cal_arith_unit and cal_dmem_model are compiled first.
`timescale 1ns/10ps
module tb;
	import cal_pkg::*;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [7:0]  awaddr = 0, araddr = 0, mem_byte, a, b, c, off;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs;
	logic [15:0] mem_addr = 0, ix, ea;
	logic [18:0] e;
	integer      seed = 14, fails = 0, checks_done = 0, cyc = 0;
	localparam logic [7:0] CORNER [4] = '{8'h00, 8'hff, 8'h80, 8'h7f};
	cal_arith_unit DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));
	cal_dmem_model u_mem (.addr(mem_addr), .data(mem_byte));
	initial forever #10 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	// bus tasks: hold each channel until its own ready edge
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		@(posedge aclk);
		awaddr <= ad;
		wdata <= wd;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] ad);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
		checks_done++;
		if (got !== ex) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, ex, got);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// expected values: {v, c, r} of add and subtract, then {z v c, dest, acc}
	function automatic logic [9:0] sub8(input logic [7:0] p, q, input logic bw);
		logic [8:0] t;
		t = {1'b0, p} - {1'b0, q} - 9'(bw);
		return {(p[7] != q[7]) && (t[7] != p[7]), !t[8], t[7:0]};
	endfunction
	function automatic logic [9:0] add8(input logic [7:0] p, q, input logic ci);
		logic [8:0] t;
		t = {1'b0, p} + {1'b0, q} + 9'(ci);
		return {(p[7] == q[7]) && (t[7] != p[7]), t[8], t[7:0]};
	endfunction
	function automatic logic [18:0] model(input logic [4:0] op, input logic [1:0] fm, input logic [2:0] s,
		input logic [7:0] a, b, c, input logic [2:0] f);
		logic [7:0]  u, v, x, bit_m;
		logic [9:0]  t;
		logic [15:0] m;
		logic        k;
		u = (fm == CAL_FORM_R3) ? b : a;
		v = (fm == CAL_FORM_R3) ? c : b;
		x = fm[1] ? b : a;
		bit_m = 8'h01 << s;
		t = {f[1], f[0], 8'h00};
		k = 1;
		m = 16'h0;
		case (op)
			CAL_OP_DEC: t = sub8(x, 8'h01, 1'b0);
			CAL_OP_DECC: t = sub8(x, {7'h0, !f[0]}, 1'b0);
			CAL_OP_AND: t[7:0] = u & v;
			CAL_OP_OR: t[7:0] = u | v;
			CAL_OP_XOR: t[7:0] = u ^ v;
			CAL_OP_ADD, CAL_OP_ADDC: t = add8(u, v, !op[0] && f[0]);
			CAL_OP_SUBD, CAL_OP_SUBDC: t = sub8(b, (fm == CAL_FORM_R3) ? c : a, !op[0] && !f[0]);
			CAL_OP_SUBS, CAL_OP_SUBSC: t = sub8((fm == CAL_FORM_R3) ? c : a, b, !op[0] && !f[0]);
			CAL_OP_MUL, CAL_OP_MULA: m = u * v;
			CAL_OP_MSHL: m = {8'h0, a} << s;
			CAL_OP_MSHR: m = {8'h0, a} << (4'h8 - {1'b0, s});
			CAL_OP_MSHRA: m = {{8{a[7]}}, a} << (4'h8 - {1'b0, s});
			CAL_OP_CMP, CAL_OP_CMPA: t = sub8(b, a, 1'b0);
			CAL_OP_TSTB: t[7:0] = a & bit_m;
			CAL_OP_SETB: t[7:0] = a | bit_m;
			CAL_OP_CLRB: t[7:0] = a & ~bit_m;
			default: t[7:0] = a ^ bit_m;
		endcase
		if (op >= CAL_OP_MUL && op <= CAL_OP_MSHRA) return {f, m};
		if (op == CAL_OP_CMP || op == CAL_OP_CMPA) t[9] = t[8] && (t[7:0] != 0);
		k = (op == CAL_OP_CMP || op == CAL_OP_CMPA || op == CAL_OP_TSTB);
		return {t[7:0] == 0, t[9:8], k ? a : t[7:0], t[7:0]};
	endfunction
	task automatic run_op(input logic [4:0] op, input logic [1:0] fm, input logic [2:0] s, md,
		input logic [7:0] a, b, c, of, input logic [2:0] f);
		e = model(op, fm, s, a, b, c, f);
		wr(CAL_OFS_OPA, {24'h0, a});
		wr(CAL_OFS_OPB, {24'h0, b});
		wr(CAL_OFS_OPC, {24'h0, c});
		wr(CAL_OFS_FLAGS, {29'h0, f});
		wr(CAL_OFS_CTRL, {of, 7'h0, 1'b1, 1'b0, md, 1'b0, s, fm, 1'b0, op});
		rd(CAL_OFS_RESULT);
		chk("result", {16'h0, e[15:0]}, {16'h0, d[15:0]});
		rd(CAL_OFS_FLAGS);
		chk("flags", {29'h0, e[18:16]}, {29'h0, d[2:0]});
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// hang guard, well above the few thousand cycles the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		// every opcode in every operand form, corner operands mixed in
		for (int op = 0; op < 22; op++) for (int fm = 0; fm < 4; fm++) begin
			a = (fm == 0) ? CORNER[op % 4] : 8'($random(seed));
			b = (fm == 3) ? CORNER[op % 4] : 8'($random(seed));
			run_op(5'(op), 2'(fm), 3'($random(seed)), 3'h0, a, b, 8'($random(seed)), 8'h0, 3'($random(seed)));
		end
		$display("test opcodes and forms done");
		// memory operand through every address mode, byte taken from the memory model
		for (int md = 0; md < 8; md++) begin
			ix = 16'($random(seed));
			off = 8'($random(seed));
			c = 8'($random(seed));
			a = 8'($random(seed));
			case (md)
				0: ea = {8'h0, off};
				1, 4: ea = ix;
				2, 5: ea = ix + off;
				3: ea = ix + c;
				6: ea = ix - 1;
				default: ea = ix - off;
			endcase
			mem_addr = ea;
			#1;
			wr(CAL_OFS_INDEX, {16'h0, ix});
			run_op(CAL_OP_XOR, CAL_FORM_MEM, 3'h0, 3'(md), a, mem_byte, c, off, 3'h0);
			rd(CAL_OFS_MADDR);
			chk("maddr", {16'h0, ea}, {16'h0, d[15:0]});
			rd(CAL_OFS_INDEX);
			chk("index", {16'h0, (md < 4) ? ix : ((md == 4) ? ix + 16'h1 : ea)}, {16'h0, d[15:0]});
		end
		$display("test address modes done");
		// refusals: unmapped read, unused opcode, sticky status cleared by writing one
		rd(8'h24);
		chk("unmapped resp", {30'h0, CAL_RESP_SLVERR}, {30'h0, rs});
		chk("unmapped data", 32'h0, d);
		wr(8'h24, 32'h0);
		chk("unmapped wr resp", {30'h0, CAL_RESP_SLVERR}, {30'h0, rs});
		wr(CAL_OFS_CTRL, 32'h0001_0016);
		rd(CAL_OFS_STATUS);
		chk("bad op", 32'h3, {30'h0, d[1:0]});
		wr(CAL_OFS_STATUS, 32'h1);
		rd(CAL_OFS_STATUS);
		chk("bad op clear", 32'h2, {30'h0, d[1:0]});
		$display("test refusals done");
		tally_and_finish;
	end
endmodule
